// [pkg/bwcr_pkg.sv]
// shared constants, types and helpers of the bus and wake configuration bank
package bwcr_pkg;
  // ------------------------------------------------------------
  // spi frame layout
  // ------------------------------------------------------------
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] HEADER_LEN = 5'h08;
  localparam logic [4:0] CNT_MAX = 5'h11;
  localparam int RX_ADDR_LSB = 8;
  localparam int RX_RW_BIT = 15;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int NUM_REGS = 5;
  localparam logic [6:0] WDOG_ADDR = 7'h03;
  localparam logic [6:0] TMC_ADDR = 7'h04;
  localparam logic [6:0] STPC_ADDR = 7'h05;
  localparam logic [6:0] IWC_ADDR = 7'h06;
  localparam logic [6:0] EWC_ADDR = 7'h07;
  localparam logic [2:0] WDOG_IDX = 3'h0;
  localparam logic [2:0] TMC_IDX = 3'h1;
  localparam logic [2:0] STPC_IDX = 3'h2;
  localparam logic [2:0] IWC_IDX = 3'h3;
  localparam logic [2:0] EWC_IDX = 3'h4;
  localparam logic [7:0] WDOG_RST = 8'h14;
  localparam logic [7:0] TMC_RST = 8'h20;
  localparam logic [7:0] STPC_RST = 8'h00;
  localparam logic [7:0] IWC_RST = 8'h00;
  localparam logic [7:0] EWC_RST = 8'h07;
  localparam logic [7:0] WDOG_WMASK = 8'hf7;
  localparam logic [7:0] TMC_WMASK = 8'hfb;
  localparam logic [7:0] STPC_WMASK = 8'h23;
  localparam logic [7:0] IWC_WMASK = 8'hc4;
  localparam logic [7:0] EWC_WMASK = 8'ha7;
  // fail-safe reload: keep mask selects bits left unchanged
  localparam logic [7:0] TMC_FS_KEEP = 8'he0;
  localparam logic [7:0] TMC_FS_VAL = 8'h09;
  localparam logic [7:0] STPC_FS_KEEP = 8'h00;
  localparam logic [7:0] STPC_FS_VAL = 8'h01;
  localparam logic [7:0] EWC_FS_KEEP = 8'ha0;
  localparam logic [7:0] EWC_FS_VAL = 8'h07;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int WDOG_STOP_DIS_BIT = 6;
  localparam int TMC_FLASH_BIT = 7;
  localparam int TMC_LSM_BIT = 6;
  localparam int TMC_TXTO_BIT = 5;
  localparam int TMC_FIRST_LIN_MODE_LSB = 3;
  localparam int TMC_CAN_LSB = 0;
  localparam int STPC_PEAK_BIT = 5;
  localparam int STPC_SECOND_LIN_MODE_LSB = 0;
  localparam int IWC_TMRB_BIT = 7;
  localparam int IWC_TMRA_BIT = 6;
  localparam int IWC_STOP_DIS_BIT = 2;
  localparam int EWC_GLOBAL_BIT = 7;
  localparam int EWC_MEAS_BIT = 5;
  localparam int EWC_WKC_BIT = 2;
  localparam int EWC_WKB_BIT = 1;
  localparam int EWC_WKA_BIT = 0;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {XCVR_OFF, XCVR_WAKE, XCVR_RX_ONLY, XCVR_NORMAL} bwcr_xcvr_e;
  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } bwcr_mode_e;
  typedef struct packed {
    logic csn_n;
    logic sclk;
    logic sdi;
  } bwcr_spi_in_s;
  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } bwcr_spi_out_s;
  typedef struct packed {
    logic lin_flash;
    logic low_slope_select;
    logic transmit_timeout_enable;
    bwcr_xcvr_e first_lin_mode;
    bwcr_xcvr_e second_lin_mode;
    bwcr_xcvr_e can_mode;
    logic can_wake_source;
    logic first_lin_wake_source;
    logic second_lin_wake_source;
    logic supply_peak_threshold;
    logic timer_a_wake_enable;
    logic timer_b_wake_enable;
    logic stop_watchdog_disable_lo;
    logic stop_watchdog_disable_hi;
    logic [7:0] watchdog_ctrl;
    logic interrupt_global;
    logic wake_measure_select;
    logic measurement_enable;
    logic wake_level_ab_ignore;
    logic wake_input_a_enable;
    logic wake_input_b_enable;
    logic wake_input_c_enable;
  } bwcr_cfg_s;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] bwcr_index(input logic [6:0] addr);
    logic [6:0] diff;
    diff = addr - WDOG_ADDR;
    return diff[2:0];
  endfunction
  function automatic logic bwcr_mapped(input logic [6:0] addr);
    return (addr >= WDOG_ADDR) && (addr <= EWC_ADDR);
  endfunction
  function automatic logic [7:0] bwcr_wmask(input logic [2:0] idx);
    logic [7:0] m;
    m = 8'h00;
    unique case (idx)
      WDOG_IDX: m = WDOG_WMASK;
      TMC_IDX: m = TMC_WMASK;
      STPC_IDX: m = STPC_WMASK;
      IWC_IDX: m = IWC_WMASK;
      EWC_IDX: m = EWC_WMASK;
      default: m = 8'h00;
    endcase
    return m;
  endfunction
endpackage

// [core/bwcr_top.sv]
// bus and wake configuration register bank behind the 16-bit spi
//
// Operation
// R01 - tmc bit 7 set bypasses lin slope control, clear keeps it active
// R02 - tmc bit 6 selects lin low-slope mode, clear selects normal
// R03 - tmc bit 5 enables lin transmit time-out
// R04 - tmc bits 4:3 give first lin mode: off, wake, rx only, normal
// R05 - tmc bits 1:0 give can mode: off, wake, rx only, normal
// R06 - lin option bits apply to both lin at chip select release
// R07 - fail-safe entry reloads the three wake registers, x bits kept
// R08 - reserved bits always read zero
// R09 - second register bit 5 selects high supply peak threshold
// R10 - peak threshold bit writable only in init or normal mode
// R11 - stop mode peak write ignored, no command error, no interrupt
// R12 - second register bits 1:0 give second lin mode
// R13 - internal wake bits 7 and 6 enable timer b and a wakes
// R14 - internal wake bit 2 disables watchdog in stop mode
// R15 - ext bit 7 clear: only wakes interrupt; set: all status interrupts
// R16 - measure select ignores wake input a and b enables
// R17 - measure active in normal mode, input a/b level status ignored
// R18 - ext bits 2,1,0 enable wake inputs c, b, a
// R19 - wake-capable transceiver code makes that transceiver a wake source
// R20 - watchdog register bit 6 disables watchdog in stop mode
// R21 - writes to reserved bits are dropped, other fields update
`timescale 1ns/1ps
module bwcr_top
  import bwcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire bwcr_pkg::bwcr_spi_in_s spi_in,
  output bwcr_pkg::bwcr_spi_out_s spi_out,
  input wire bwcr_pkg::bwcr_mode_e sbc_mode,
  input wire logic fail_safe_entry,
  input wire logic wake_event,
  input wire logic status_event,
  input wire logic spi_fail_clear,
  output bwcr_pkg::bwcr_cfg_s cfg,
  output logic spi_fail,
  output logic int_request
);
  import bwcr_pkg::*;

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [2:0] csn_ff;
  logic [2:0] sclk_ff;
  logic [1:0] sdi_ff;
  logic csn_fall;
  logic csn_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_on;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // second and third stages feed the edge detectors and the sclk-stable check of the read load, never the first stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csn_ff <= 3'h7;
      sclk_ff <= 3'h0;
      sdi_ff <= 2'h0;
    end
    else
    begin
      csn_ff <= {csn_ff[1:0], spi_in.csn_n};
      sclk_ff <= {sclk_ff[1:0], spi_in.sclk};
      sdi_ff <= {sdi_ff[0], spi_in.sdi};
    end
  end

  assign frame_on = !csn_ff[1];
  assign csn_fall = !csn_ff[1] && csn_ff[2];
  assign csn_rise = csn_ff[1] && !csn_ff[2];
  assign sclk_rise = frame_on && sclk_ff[1] && !sclk_ff[2];
  assign sclk_fall = frame_on && !sclk_ff[1] && sclk_ff[2];

  // ------------------------------------------------------------
  // frame shifter, lsb first: addr[6:0], write flag, data[7:0]
  // ------------------------------------------------------------
  logic [4:0] bit_cnt_ff;
  logic [15:0] rx_ff;
  logic [7:0] tx_ff;
  logic sdo_ff;
  logic [7:0] regs_ff [NUM_REGS];
  logic spi_fail_ff;
  logic [6:0] hdr_addr;
  logic [7:0] rd_value;

  assign hdr_addr = rx_ff[RX_RW_BIT-1:RX_ADDR_LSB];
  assign rd_value = bwcr_mapped(hdr_addr) ? regs_ff[bwcr_index(hdr_addr)] : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
    end
    else if (csn_fall)
    begin
      bit_cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
    end
    else if (sclk_fall)
    begin
      // saturate so an overlong frame stays distinguishable
      if (bit_cnt_ff != CNT_MAX)
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      rx_ff <= {sdi_ff[1], rx_ff[15:1]};
    end
  end

  // status byte first, then the addressed register as it was before the write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_ff <= 8'h00;
      sdo_ff <= 1'b0;
    end
    else if (csn_fall)
    begin
      tx_ff <= {7'h00, spi_fail_ff};
      sdo_ff <= 1'b0;
    end
    else if (sclk_rise)
    begin
      sdo_ff <= tx_ff[0];
      tx_ff <= {1'b0, tx_ff[7:1]};
    end
    else if (frame_on && bit_cnt_ff == HEADER_LEN && sclk_ff[1] == sclk_ff[2] && !sclk_ff[1])
      tx_ff <= rd_value; // R08
  end

  assign spi_out.sdo = sdo_ff;
  assign spi_out.sdo_oe = frame_on;

  // ------------------------------------------------------------
  // commit at chip select release
  // ------------------------------------------------------------
  logic frame_ok;
  logic commit;
  logic [6:0] cmd_addr;
  logic [2:0] cmd_idx;
  logic [7:0] cmd_data;
  logic peak_locked;
  logic [7:0] wr_value;

  assign frame_ok = (bit_cnt_ff == FRAME_LEN);
  assign cmd_addr = rx_ff[6:0];
  assign cmd_idx = bwcr_index(cmd_addr);
  assign cmd_data = rx_ff[15:8];
  assign commit = csn_rise && frame_ok && rx_ff[7] && bwcr_mapped(cmd_addr); // R06
  assign peak_locked = !(sbc_mode == MODE_INIT || sbc_mode == MODE_NORMAL); // R10

  always_comb
  begin
    wr_value = cmd_data & bwcr_wmask(cmd_idx); // R21
    if (cmd_idx == STPC_IDX && peak_locked)
      wr_value[STPC_PEAK_BIT] = regs_ff[STPC_IDX][STPC_PEAK_BIT]; // R11
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs_ff[WDOG_IDX] <= WDOG_RST;
      regs_ff[TMC_IDX] <= TMC_RST;
      regs_ff[STPC_IDX] <= STPC_RST;
      regs_ff[IWC_IDX] <= IWC_RST;
      regs_ff[EWC_IDX] <= EWC_RST;
    end
    else
    begin
      if (commit)
        regs_ff[cmd_idx] <= wr_value;
      // reload wins over a write in the same cycle so the chip stays wakeable
      if (fail_safe_entry)
      begin
        regs_ff[TMC_IDX] <= (regs_ff[TMC_IDX] & TMC_FS_KEEP) | TMC_FS_VAL; // R07
        regs_ff[STPC_IDX] <= (regs_ff[STPC_IDX] & STPC_FS_KEEP) | STPC_FS_VAL; // R07
        regs_ff[EWC_IDX] <= (regs_ff[EWC_IDX] & EWC_FS_KEEP) | EWC_FS_VAL; // R07
      end
    end
  end

  // bad length or unmapped address is a command error; the stop-mode peak
  // write is a legal frame and therefore never lands here
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      spi_fail_ff <= 1'b0;
    else if (csn_rise && (!frame_ok || !bwcr_mapped(cmd_addr)))
      spi_fail_ff <= 1'b1; // R11
    else if (spi_fail_clear)
      spi_fail_ff <= 1'b0;
  end
  assign spi_fail = spi_fail_ff;

  // ------------------------------------------------------------
  // interrupt scope
  // ------------------------------------------------------------
  logic int_ff;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      int_ff <= 1'b0;
    else
      int_ff <= wake_event || (status_event && regs_ff[EWC_IDX][EWC_GLOBAL_BIT]); // R15
  end
  assign int_request = int_ff;

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------
  logic meas_sel;

  assign meas_sel = regs_ff[EWC_IDX][EWC_MEAS_BIT];

  always_comb
  begin
    cfg.lin_flash = regs_ff[TMC_IDX][TMC_FLASH_BIT]; // R01
    cfg.low_slope_select = regs_ff[TMC_IDX][TMC_LSM_BIT]; // R02
    cfg.transmit_timeout_enable = regs_ff[TMC_IDX][TMC_TXTO_BIT]; // R03
    cfg.first_lin_mode = bwcr_xcvr_e'(regs_ff[TMC_IDX][TMC_FIRST_LIN_MODE_LSB+:2]); // R04
    cfg.can_mode = bwcr_xcvr_e'(regs_ff[TMC_IDX][TMC_CAN_LSB+:2]); // R05
    cfg.second_lin_mode = bwcr_xcvr_e'(regs_ff[STPC_IDX][STPC_SECOND_LIN_MODE_LSB+:2]); // R12
    cfg.can_wake_source = (cfg.can_mode == XCVR_WAKE); // R19
    cfg.first_lin_wake_source = (cfg.first_lin_mode == XCVR_WAKE); // R19
    cfg.second_lin_wake_source = (cfg.second_lin_mode == XCVR_WAKE); // R19
    cfg.supply_peak_threshold = regs_ff[STPC_IDX][STPC_PEAK_BIT]; // R09
    cfg.timer_b_wake_enable = regs_ff[IWC_IDX][IWC_TMRB_BIT]; // R13
    cfg.timer_a_wake_enable = regs_ff[IWC_IDX][IWC_TMRA_BIT]; // R13
    cfg.stop_watchdog_disable_hi = regs_ff[IWC_IDX][IWC_STOP_DIS_BIT]; // R14
    cfg.stop_watchdog_disable_lo = regs_ff[WDOG_IDX][WDOG_STOP_DIS_BIT]; // R20
    cfg.watchdog_ctrl = regs_ff[WDOG_IDX];
    cfg.interrupt_global = regs_ff[EWC_IDX][EWC_GLOBAL_BIT]; // R15
    cfg.wake_measure_select = meas_sel;
    cfg.measurement_enable = meas_sel && (sbc_mode == MODE_NORMAL); // R17
    cfg.wake_level_ab_ignore = meas_sel; // R17
    cfg.wake_input_a_enable = regs_ff[EWC_IDX][EWC_WKA_BIT] && !meas_sel; // R16
    cfg.wake_input_b_enable = regs_ff[EWC_IDX][EWC_WKB_BIT] && !meas_sel; // R16
    cfg.wake_input_c_enable = regs_ff[EWC_IDX][EWC_WKC_BIT]; // R18
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_tmc_write;
    commit && cmd_idx == TMC_IDX && !fail_safe_entry;
  endsequence
  sequence s_peak_write_stop;
    commit && cmd_idx == STPC_IDX && peak_locked && !fail_safe_entry;
  endsequence
  sequence s_peak_write_open;
    commit && cmd_idx == STPC_IDX && !peak_locked && !fail_safe_entry;
  endsequence

  AST_FS_TMC: assert property (fail_safe_entry |=> regs_ff[TMC_IDX][4:0] == 5'h09 && // R07
    regs_ff[TMC_IDX][7:5] == $past(regs_ff[TMC_IDX][7:5]))
    else $error("fail-safe reload of transceiver mode wrong");
  AST_FS_EXT: assert property (fail_safe_entry |=> (regs_ff[EWC_IDX] & 8'h5f) == 8'h07 && // R07
    cfg.second_lin_mode == XCVR_WAKE)
    else $error("fail-safe reload of wake registers wrong");
  AST_RSVD_ZERO: assert property ((regs_ff[TMC_IDX] & ~TMC_WMASK) == 8'h00 && // R08
    (regs_ff[STPC_IDX] & ~STPC_WMASK) == 8'h00 && (regs_ff[IWC_IDX] & ~IWC_WMASK) == 8'h00)
    else $error("reserved bit holds a one");
  AST_LSM_COMMIT: assert property (s_tmc_write |=> cfg.low_slope_select == $past(cmd_data[6]) && // R06
    cfg.lin_flash == $past(cmd_data[7]) && cfg.transmit_timeout_enable == $past(cmd_data[5]))
    else $error("lin options not applied at frame end");
  AST_STOP_PEAK: assert property (s_peak_write_stop |=> $stable(cfg.supply_peak_threshold) && // R11
    !$rose(spi_fail_ff))
    else $error("stop-mode peak write not ignored");
  AST_OPEN_PEAK: assert property (s_peak_write_open |=> // R10
    cfg.supply_peak_threshold == $past(cmd_data[5]))
    else $error("peak threshold write lost in init or normal");
  AST_MEAS_MASK: assert property (meas_sel |-> !cfg.wake_input_a_enable && // R16
    !cfg.wake_input_b_enable)
    else $error("wake inputs a/b active while measuring");
  AST_INT_SCOPE: assert property (status_event && !wake_event && !cfg.interrupt_global // R15
    |=> !int_request)
    else $error("non-wake status raised interrupt");
  AST_CAN_WAKE: assert property (s_tmc_write ##1 cfg.can_mode == XCVR_WAKE // R19
    |-> cfg.can_wake_source && $past(cmd_data[1:0]) == 2'h1)
    else $error("can wake source mismatch");
endmodule

// [sim/bwcr_host_model.sv]
// host spi master model that sends frames to the configuration bank
`timescale 1ns/1ps
module bwcr_host_model
  import bwcr_pkg::*;
(
  input wire logic clk_sys,
  output bwcr_pkg::bwcr_spi_in_s spi_in,
  input wire bwcr_pkg::bwcr_spi_out_s spi_out
);
  // ------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------
  // half period well above the 3-cycle synchroniser minimum
  localparam int HALF = 6;
  initial spi_in = '{csn_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // sdi set on rising sclk, sdo taken just before the fall
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [15:0] miso);
    miso = 16'h0000;
    @(posedge clk_sys);
    spi_in.csn_n <= 1'b0;
    wait_clk(HALF);
    for (int i = 0; i < nbits; i++)
    begin
      spi_in.sclk <= 1'b1;
      spi_in.sdi <= frame[i];
      wait_clk(HALF);
      miso[i] = spi_out.sdo;
      spi_in.sclk <= 1'b0;
      wait_clk(HALF);
    end
    spi_in.csn_n <= 1'b1;
    // released data line must not keep showing the last bit
    spi_in.sdi <= ~spi_in.sdi;
    wait_clk(HALF);
  endtask
endmodule

// [sim/bus_wake_config_registers_bench.sv]
// self-checking bench of the bus and wake configuration bank
`timescale 1ns/1ps
module bus_wake_config_registers_bench;
  import bwcr_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  bwcr_spi_in_s spi_in;
  bwcr_spi_out_s spi_out;
  bwcr_mode_e sbc_mode = MODE_NORMAL;
  logic fail_safe_entry = 1'b0;
  logic wake_event = 1'b0;
  logic status_event = 1'b0;
  logic spi_fail_clear = 1'b0;
  bwcr_cfg_s cfg;
  logic spi_fail;
  logic int_request;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_int = 0;
  int n_int0 = 0;
  int n_oe = 0;
  logic [15:0] miso;
  logic [1:0] m;
  logic [6:0] addrs [5] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07};
  logic [7:0] rstv [5] = '{8'h14, 8'h20, 8'h00, 8'h00, 8'h07};
  logic [7:0] fullv [5] = '{8'hf7, 8'hfb, 8'h23, 8'hc4, 8'ha7};
  bwcr_top bwcr_top_inst(.clk_sys(clk_sys), .resetn(resetn), .spi_in(spi_in),
    .spi_out(spi_out), .sbc_mode(sbc_mode), .fail_safe_entry(fail_safe_entry),
    .wake_event(wake_event), .status_event(status_event), .spi_fail_clear(spi_fail_clear),
    .cfg(cfg), .spi_fail(spi_fail), .int_request(int_request));
  bwcr_host_model bwcr_host_model_inst(.clk_sys(clk_sys), .spi_in(spi_in), .spi_out(spi_out));
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (int_request === 1'b1)
      n_int++;
    // output enable must stand exactly as long as the synced chip select is low
    if (spi_out.sdo_oe === 1'b1)
      n_oe++;
    if (cycles == 40000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    bwcr_host_model_inst.xfer({d, 1'b1, a}, 16, miso);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    bwcr_host_model_inst.xfer({8'h00, 1'b0, a}, 16, miso);
    check("read data", exp, miso[15:8]);
  endtask
  task automatic set_mode(input bwcr_mode_e md);
    @(posedge clk_sys);
    sbc_mode <= md;
  endtask
  task automatic pulse_int(input logic wk, input logic st, input logic [7:0] exp);
    int n0;
    n0 = n_int;
    @(posedge clk_sys);
    wake_event <= wk;
    status_event <= st;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    status_event <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check("int pulses", exp, 8'(n_int - n0));
  endtask
  task automatic clear_fail();
    @(posedge clk_sys);
    spi_fail_clear <= 1'b1;
    @(posedge clk_sys);
    spi_fail_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("spi fail", 8'h00, {7'h0, spi_fail});
  endtask
  function automatic logic [7:0] opts();
    return {5'h0, cfg.lin_flash, cfg.low_slope_select, cfg.transmit_timeout_enable};
  endfunction
  function automatic logic [7:0] wks();
    return {2'h0, cfg.wake_level_ab_ignore, cfg.interrupt_global, cfg.measurement_enable,
      cfg.wake_input_c_enable, cfg.wake_input_b_enable, cfg.wake_input_a_enable};
  endfunction
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("oe idle", 8'h00, {7'h0, spi_out.sdo_oe});
    for (int i = 0; i < 5; i++)
      rd_chk(addrs[i], rstv[i]);
    // each 16-bit host frame holds chip select low for 198 clocks
    check("oe cycles", 8'hc6, 8'(n_oe / 5));
    for (int i = 0; i < 5; i++)
    begin
      wr(addrs[i], 8'hff);
      check("old value", rstv[i], miso[15:8]);
      check("status", 8'h00, miso[7:0]);
      rd_chk(addrs[i], fullv[i]);
    end
    check("opts", 8'h07, opts());
    check("timers", 8'h0f, {4'h0, cfg.timer_b_wake_enable, cfg.timer_a_wake_enable,
      cfg.stop_watchdog_disable_hi, cfg.stop_watchdog_disable_lo});
    check("wake normal", 8'h3c, wks());
    check("peak", 8'h01, {7'h0, cfg.supply_peak_threshold});
    check("wdog cfg", 8'hf7, cfg.watchdog_ctrl);
    set_mode(MODE_INIT);
    repeat (3) @(posedge clk_sys);
    check("wake init", 8'h34, wks());
    wr(EWC_ADDR, 8'h07);
    check("wake inputs", 8'h07, wks());
    for (int j = 0; j < 3; j++)
    begin
      wr(TMC_ADDR, 8'h80 >> j);
      check("opts one", 8'h04 >> j, opts());
    end
    $display("test field map done");
    for (int k = 0; k < 4; k++)
    begin
      m = k[1:0];
      wr(TMC_ADDR, {3'h0, m, 1'b1, m});
      wr(STPC_ADDR, {6'h0, m});
      check("can mode", {6'h0, m}, {6'h0, cfg.can_mode});
      check("lin a mode", {6'h0, m}, {6'h0, cfg.first_lin_mode});
      check("lin b mode", {6'h0, m}, {6'h0, cfg.second_lin_mode});
      check("wake src", (k == 1) ? 8'h07 : 8'h00, {5'h0, cfg.can_wake_source,
        cfg.first_lin_wake_source, cfg.second_lin_wake_source});
      rd_chk(TMC_ADDR, {3'h0, m, 1'b0, m});
    end
    $display("test transceiver modes done");
    set_mode(MODE_STOP);
    n_int0 = n_int;
    wr(STPC_ADDR, 8'h21);
    pulse_int(1'b0, 1'b0, 8'h00);
    check("int stop", 8'h00, 8'(n_int - n_int0));
    check("peak stop", 8'h00, {7'h0, cfg.supply_peak_threshold});
    check("lin b stop", 8'h01, {6'h0, cfg.second_lin_mode});
    check("fail stop", 8'h00, {7'h0, spi_fail});
    set_mode(MODE_INIT);
    wr(STPC_ADDR, 8'h21);
    check("peak init", 8'h01, {7'h0, cfg.supply_peak_threshold});
    set_mode(MODE_NORMAL);
    wr(STPC_ADDR, 8'h01);
    check("peak low", 8'h00, {7'h0, cfg.supply_peak_threshold});
    $display("test peak threshold done");
    pulse_int(1'b0, 1'b1, 8'h00);
    pulse_int(1'b1, 1'b0, 8'h01);
    wr(EWC_ADDR, 8'h87);
    pulse_int(1'b0, 1'b1, 8'h01);
    $display("test interrupt scope done");
    wr(TMC_ADDR, 8'hf6);
    wr(STPC_ADDR, 8'h22);
    wr(EWC_ADDR, 8'h80);
    wr(IWC_ADDR, 8'h40);
    @(posedge clk_sys);
    fail_safe_entry <= 1'b1;
    @(posedge clk_sys);
    fail_safe_entry <= 1'b0;
    rd_chk(TMC_ADDR, 8'he9);
    rd_chk(STPC_ADDR, 8'h01);
    rd_chk(EWC_ADDR, 8'h87);
    rd_chk(IWC_ADDR, 8'h40);
    $display("test fail-safe reload done");
    bwcr_host_model_inst.xfer({8'h00, 1'b1, TMC_ADDR}, 15, miso);
    check("fail short", 8'h01, {7'h0, spi_fail});
    rd_chk(TMC_ADDR, 8'he9);
    check("status fail", 8'h01, miso[7:0]);
    clear_fail();
    wr(7'h10, 8'hff);
    check("unmapped", 8'h00, miso[15:8]);
    check("fail unmapped", 8'h01, {7'h0, spi_fail});
    clear_fail();
    $display("test frame errors done");
    report_and_stop();
  end
endmodule
